// >>> design/buck_fault_supervisor.sv
// Supervisory sequencer of a synchronous buck: shutdown, hiccup, thermal, tracking, power good.
// Assumes comparator results arrive asynchronously; registers on APB at pclk.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// How it works
// - Enable comparator low turns both gate drivers off (tristated).
// - Soft-start pin below 0.3V stops regulation until a fresh ramp runs.
// - Current-limit pin below ground during low-side conduction flags over-current.
// - Over-current latches trip flag and enters hiccup, restarting soft-start.
// - Hiccup grounds soft-start for 4096 switching cycles, then clears trip flag.
// - Over-current after each soft-start re-enters hiccup until fault clears.
// - Over-current sampling blanked 160 ns after low-side drive rises.
// - Over-temperature turns both switches off and discharges soft-start.
// - Restart automatically once over-temperature indication clears.
// - Target follows tracking input until above 0.85V, then internal reference.
// - Feedback in regulation only inside 0.595V to 0.805V window.
// - Power good is open drain; released when in regulation, pull-up external.
// - Non-tracking startup holds power good low until soft-start reaches 2.1V.
// - Power good released 256 switching cycles after feedback enters window.
// - High-side off-time of at least 200 ns each switching cycle.
// - High-side pulses under 50 ns are skipped.
// - Power-on-ready from bias and enable lockouts starts soft-start.
// - Pre-bias start keeps low side off, then steps 25/50/75/100 percent.
module buck_fault_supervisor #(
   parameter int SOFTSTART_CYCLES = buck_sup_pkg::SOFTSTART_DEFAULT,
   parameter int HICCUP_CYCLES = buck_sup_pkg::HICCUP_SW_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enable_above_thr,
   input wire logic bias_above_uvlo,
   input wire logic softstart_below_0v3,
   input wire logic softstart_above_2v1,
   input wire logic ocset_below_gnd,
   input wire logic overtemp,
   input wire logic track_above_0v85,
   input wire logic feedback_input_above_low,
   input wire logic feedback_input_above_high,
   output logic hs_gate,
   output logic ls_gate,
   output logic drivers_tristate,
   output logic softstart_discharge,
   output logic ref_internal_sel,
   output logic output_in_regulation_o,
   output logic output_in_regulation_oe,
   output logic overcurrent_trip
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   logic [8:0] pins_s;
   sync2 #(.W(9)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({enable_above_thr, bias_above_uvlo, softstart_below_0v3, softstart_above_2v1,
         ocset_below_gnd, overtemp, track_above_0v85, feedback_input_above_low,
         feedback_input_above_high}),
      .q(pins_s)
   );
   logic en_s, bias_s, ss_low_s, ss_2v1_s, oc_s, ot_s, trk_s, fb_lo_s, fb_hi_s;
   assign {en_s, bias_s, ss_low_s, ss_2v1_s, oc_s, ot_s, trk_s, fb_lo_s, fb_hi_s} = pins_s;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] ctrl_reg;
   logic [15:0] duty_reg;
   logic [15:0] period_reg;
   logic [31:0] status_w;
   logic wr_en, rd_en, addr_ok;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign addr_ok = (paddr == buck_sup_pkg::CTRL_OFF) || (paddr == buck_sup_pkg::STATUS_OFF)
      || (paddr == buck_sup_pkg::DUTY_OFF) || (paddr == buck_sup_pkg::PERIOD_OFF);
   logic [31:0] rd_mux;
   assign rd_mux = (paddr == buck_sup_pkg::CTRL_OFF) ? ctrl_reg :
      (paddr == buck_sup_pkg::STATUS_OFF) ? status_w :
      (paddr == buck_sup_pkg::DUTY_OFF) ? {16'h0000, duty_reg} :
      (paddr == buck_sup_pkg::PERIOD_OFF) ? {16'h0000, period_reg} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= buck_sup_pkg::CTRL_RESET;
         duty_reg <= buck_sup_pkg::DUTY_RESET;
         period_reg <= buck_sup_pkg::PERIOD_RESET;
      end else if (wr_en) begin
         if (paddr == buck_sup_pkg::CTRL_OFF) ctrl_reg <= {31'h0, pwdata[0]};
         if (paddr == buck_sup_pkg::DUTY_OFF) duty_reg <= pwdata[15:0];
         if (paddr == buck_sup_pkg::PERIOD_OFF) period_reg <= pwdata[15:0];
      end
   end

   // Answer in the access cycle: pready one cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_en) prdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Switching-cycle timer
   sw_tick_if st ();
   gate_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .period(period_reg),
      .t(st.timer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   buck_sup_pkg::sup_state_t state_reg, state_next;
   logic por, shutdown, oc_event, blank_done;
   logic [12:0] hic_reg;
   logic [15:0] ss_reg;
   logic [8:0] pg_reg;
   logic [4:0] blank_reg;
   logic trip_reg;
   logic hic_done, ss_done, win_ok, pg_qual;
   assign por = en_s && bias_s && ctrl_reg[buck_sup_pkg::CTRL_SW_EN_BIT];
   assign shutdown = !por || ot_s;
   assign blank_done = (blank_reg == 5'(buck_sup_pkg::BLANK_CYC));
   assign oc_event = st.ls_on && blank_done && oc_s;
   assign hic_done = (hic_reg == 13'(HICCUP_CYCLES));
   assign ss_done = (ss_reg == 16'(SOFTSTART_CYCLES));
   assign win_ok = fb_lo_s && !fb_hi_s;
   assign pg_qual = win_ok && state_reg == buck_sup_pkg::ST_RUN && (ss_2v1_s || !trk_s);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         buck_sup_pkg::ST_OFF: if (!shutdown) state_next = buck_sup_pkg::ST_SOFTSTART;
         buck_sup_pkg::ST_SOFTSTART: begin
            if (oc_event) state_next = buck_sup_pkg::ST_HICCUP;
            else if (ss_low_s) state_next = buck_sup_pkg::ST_SOFTSTART;
            else if (ss_done) state_next = buck_sup_pkg::ST_RUN;
         end
         buck_sup_pkg::ST_RUN: begin
            if (oc_event) state_next = buck_sup_pkg::ST_HICCUP;
            else if (ss_low_s) state_next = buck_sup_pkg::ST_SOFTSTART;
         end
         buck_sup_pkg::ST_HICCUP: if (hic_done) state_next = buck_sup_pkg::ST_SOFTSTART;
         buck_sup_pkg::ST_THERMAL: if (!ot_s) state_next = buck_sup_pkg::ST_OFF;
         default: state_next = buck_sup_pkg::ST_OFF;
      endcase
      if (ot_s) state_next = buck_sup_pkg::ST_THERMAL;
      else if (!por) state_next = buck_sup_pkg::ST_OFF;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= buck_sup_pkg::ST_OFF;
         hic_reg <= 13'h0000;
         ss_reg <= 16'h0000;
         pg_reg <= 9'h000;
         blank_reg <= 5'h00;
         trip_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         blank_reg <= !st.ls_on ? 5'h00 : (blank_done ? blank_reg : blank_reg + 5'h01);
         if (shutdown) trip_reg <= 1'b0;
         else if (oc_event) trip_reg <= 1'b1;
         else if (hic_done) trip_reg <= 1'b0;
         if (state_reg != buck_sup_pkg::ST_HICCUP || shutdown) hic_reg <= 13'h0000;
         else if (st.sw_tick && !hic_done) hic_reg <= hic_reg + 13'h0001;
         if (state_reg != buck_sup_pkg::ST_SOFTSTART || ss_low_s) ss_reg <= 16'h0000;
         else if (!ss_done) ss_reg <= ss_reg + 16'h0001;
         if (!pg_qual) pg_reg <= 9'h000;
         else if (st.sw_tick && pg_reg != 9'(buck_sup_pkg::OUTPUT_IN_REGULATION_SW_CYCLES))
            pg_reg <= pg_reg + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   logic running;
   assign running = (state_reg == buck_sup_pkg::ST_SOFTSTART || state_reg == buck_sup_pkg::ST_RUN)
      && !ss_low_s;
   assign st.run = running;
   assign st.duty = duty_reg;
   assign status_w = {21'h0, state_reg, 3'h0, !trk_s, output_in_regulation_o == 1'b0
      && output_in_regulation_oe == 1'b0, por, ot_s, trip_reg};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_gate <= 1'b0;
         ls_gate <= 1'b0;
         drivers_tristate <= 1'b1;
         softstart_discharge <= 1'b1;
         ref_internal_sel <= 1'b0;
         output_in_regulation_o <= 1'b0;
         output_in_regulation_oe <= 1'b1;
         overcurrent_trip <= 1'b0;
      end else begin
         hs_gate <= st.hs_on;
         ls_gate <= st.ls_on;
         drivers_tristate <= !running;
         softstart_discharge <= state_reg == buck_sup_pkg::ST_HICCUP
            || state_reg == buck_sup_pkg::ST_THERMAL || state_reg == buck_sup_pkg::ST_OFF;
         ref_internal_sel <= trk_s;
         output_in_regulation_o <= 1'b0;
         output_in_regulation_oe <= pg_reg != 9'(buck_sup_pkg::OUTPUT_IN_REGULATION_SW_CYCLES);
         overcurrent_trip <= trip_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   hiccup_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
      oc_event && !shutdown |=> trip_reg && state_reg == buck_sup_pkg::ST_HICCUP)
      else $error("over-current did not enter hiccup");
   enable_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !por |=> ##1 drivers_tristate && !hs_gate && !ls_gate)
      else $error("drivers not off with enable low");
   thermal_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      ot_s |=> ##1 drivers_tristate && softstart_discharge)
      else $error("thermal shutdown not applied");
   shutdown_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown |=> !trip_reg && hic_reg == 13'h0000)
      else $error("hiccup state not cleared in shutdown");
   hiccup_end_a: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg == buck_sup_pkg::ST_HICCUP && hic_done && !shutdown
      |=> state_reg == buck_sup_pkg::ST_SOFTSTART && !trip_reg)
      else $error("hiccup end wrong");
   blank_a: assert property (@(posedge pclk) disable iff (!presetn)
      st.ls_rise |-> !oc_event [*8])
      else $error("over-current sampled inside blanking");
   output_in_regulation_win_a: assert property (@(posedge pclk) disable iff (!presetn)
      !win_ok |=> ##1 output_in_regulation_oe)
      else $error("power good released outside window");
   ref_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      ref_internal_sel == $past(trk_s))
      else $error("reference select wrong");
   softstart_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      ss_low_s |=> drivers_tristate)
      else $error("regulation not stopped with soft-start low");
   output_in_regulation_od_a: assert property (@(posedge pclk) disable iff (!presetn)
      !output_in_regulation_o)
      else $error("power good drives high");
endmodule : buck_fault_supervisor

// >>> design/buck_sup_pkg.sv
// Shared constants for the buck fault supervisor.
// Assumes a single 100 MHz pclk domain.
package buck_sup_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // Timing figures
   localparam int BLANK_NS = 160;
   localparam int OFF_TIME_NS = 200;
   localparam int MIN_ON_NS = 50;
   localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OFF_CYC = (OFF_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : OFF_TIME_NS / CLK_PERIOD_NS;
   localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_SW_CYCLES = 4096;
   localparam int OUTPUT_IN_REGULATION_SW_CYCLES = 256;
   localparam int SW_PERIOD_DEFAULT = 200;
   localparam int SOFTSTART_DEFAULT = 8000;
   localparam int PREBIAS_STEP_PULSES = 4;
   // Registers
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_OFF = 12'h004;
   localparam logic [11:0] DUTY_OFF = 12'h008;
   localparam logic [11:0] PERIOD_OFF = 12'h00c;
   localparam int CTRL_SW_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [15:0] DUTY_RESET = 16'h0040;
   localparam logic [15:0] PERIOD_RESET = 16'h00c8;
   localparam int ST_OCP_BIT = 0;
   localparam int ST_THERM_BIT = 1;
   localparam int ST_POR_BIT = 2;
   localparam int ST_OUTPUT_IN_REGULATION_BIT = 3;
   localparam int ST_TRACK_BIT = 4;
   localparam int ST_STATE_LSB = 8;
   typedef enum logic [2:0] {ST_OFF, ST_SOFTSTART, ST_RUN, ST_HICCUP, ST_THERMAL} sup_state_t;
endpackage : buck_sup_pkg

// >>> design/sw_tick_if.sv
// Switching-cycle timing bundle shared between supervisor and gate timer.
// Assumes all members are on pclk.
`timescale 1ns/1ps
interface sw_tick_if;
   logic sw_tick;
   logic run;
   logic [15:0] duty;
   logic hs_on;
   logic ls_on;
   logic ls_first_pulse;
   logic ls_rise;
   modport timer (input run, input duty, output sw_tick, output hs_on, output ls_on,
      output ls_first_pulse, output ls_rise);
   modport sup (output run, output duty, input sw_tick, input hs_on, input ls_on,
      input ls_first_pulse, input ls_rise);
endinterface : sw_tick_if

// >>> design/sync2.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes asynchronous comparator outputs.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : sync2

// >>> design/gate_timer.sv
// Switching-cycle oscillator and high/low side gate timing.
// Assumes period sets the cycle length in pclk counts.
`timescale 1ns/1ps
module gate_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] period,
   sw_tick_if.timer t
);
   logic [15:0] cnt_reg;
   logic [2:0] ramp_reg;
   logic [15:0] per_eff;
   logic [15:0] on_max;
   logic [15:0] duty_eff;
   logic [15:0] ls_len;
   logic ls_prev_reg;
   localparam logic [15:0] OFFC = 16'(buck_sup_pkg::OFF_CYC);
   localparam logic [15:0] MINON = 16'(buck_sup_pkg::MIN_ON_CYC);
   assign per_eff = (period < OFFC + MINON + 16'h0002) ? OFFC + MINON + 16'h0002 : period;
   assign on_max = per_eff - OFFC;
   // Clamp on-time; widths under the minimum are skipped
   assign duty_eff = (t.duty > on_max) ? on_max : ((t.duty < MINON) ? 16'h0000 : t.duty);
   assign ls_len = ((per_eff - duty_eff) >> 2) * 16'({13'h0000, ramp_reg});
   // Oscillator runs free at the programmed period, so hiccup counts real cycles
   assign t.sw_tick = (cnt_reg >= per_eff - 16'h0001);
   assign t.hs_on = t.run && (cnt_reg < duty_eff);
   assign t.ls_on = t.run && t.ls_first_pulse && (cnt_reg >= duty_eff)
      && (cnt_reg < duty_eff + ls_len);
   assign t.ls_first_pulse = (ramp_reg != 3'h0);
   assign t.ls_rise = t.ls_on && !ls_prev_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 16'h0000;
         ramp_reg <= 3'h0;
         ls_prev_reg <= 1'b0;
      end else begin
         ls_prev_reg <= t.ls_on;
         cnt_reg <= t.sw_tick ? 16'h0000 : cnt_reg + 16'h0001;
         if (!t.run) begin
            ramp_reg <= 3'h0;
         end else if (t.sw_tick && duty_eff != 16'h0000 && ramp_reg < 3'h4) begin
            ramp_reg <= ramp_reg + 3'h1;
         end
      end
   end
endmodule : gate_timer

// >>> sim/board_model.sv
// Board side of the supervisor: soft-start capacitor, current sense, power good pull-up.
// Assumes fault and hold requests arrive on pclk from the bench.
`timescale 1ns/1ps
module board_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic softstart_discharge,
   input wire logic ls_gate,
   input wire logic oc_fault,
   input wire logic ss_hold_low,
   input wire logic pg_o,
   input wire logic pg_oe,
   output logic softstart_below_0v3,
   output logic softstart_above_2v1,
   output logic ocset_below_gnd,
   output logic pg_line
);
   logic [7:0] ss_level_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // Capacitor charges while neither shorted by the device nor pulled low outside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ss_level_reg <= 8'h00;
      end else if (softstart_discharge || ss_hold_low) begin
         ss_level_reg <= 8'h00;
      end else if (ss_level_reg != 8'hff) begin
         ss_level_reg <= ss_level_reg + 8'h01;
      end
   end
   assign softstart_below_0v3 = ss_level_reg < 8'h0a;
   assign softstart_above_2v1 = ss_level_reg > 8'h46;
   // Sense pin dips below ground only while the low side conducts an overload
   assign ocset_below_gnd = oc_fault && ls_gate;
   // External pull-up on the open-drain line
   assign pg_line = pg_oe ? pg_o : 1'b1;
endmodule : board_model

// >>> sim/testbench.sv
// Self-checking bench for the buck fault supervisor over APB.
// Assumes board_model on the far side; short soft-start and hiccup counts.
`timescale 1ns/1ps
module testbench;
   localparam int PER = 32;
   localparam int HIC = 8;
   localparam int PGD = buck_sup_pkg::OUTPUT_IN_REGULATION_SW_CYCLES * PER;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, e, en = 1'b0, bias = 1'b0, ot = 1'b0, trk = 1'b1;
   logic fb_lo = 1'b1, fb_hi = 1'b0, oc_fault = 1'b0, ss_hold = 1'b0;
   logic ss_low, ss_2v1, oc_lo, hs_gate, ls_gate, tri_st, dis, ref_int, pg_o, pg_oe, trip, pg_line;
   int failures = 0, checks_done = 0, cyc = 0, n;
   always #5 pclk = ~pclk;
   buck_fault_supervisor #(.SOFTSTART_CYCLES(50), .HICCUP_CYCLES(HIC)) i_buck_fault_supervisor (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .enable_above_thr(en), .bias_above_uvlo(bias), .softstart_below_0v3(ss_low),
      .softstart_above_2v1(ss_2v1), .ocset_below_gnd(oc_lo), .overtemp(ot),
      .track_above_0v85(trk), .feedback_input_above_low(fb_lo),
      .feedback_input_above_high(fb_hi), .hs_gate(hs_gate), .ls_gate(ls_gate),
      .drivers_tristate(tri_st), .softstart_discharge(dis), .ref_internal_sel(ref_int),
      .output_in_regulation_o(pg_o), .output_in_regulation_oe(pg_oe), .overcurrent_trip(trip));
   board_model i_board_model (.pclk(pclk), .presetn(presetn), .softstart_discharge(dis),
      .ls_gate(ls_gate), .oc_fault(oc_fault), .ss_hold_low(ss_hold), .pg_o(pg_o),
      .pg_oe(pg_oe), .softstart_below_0v3(ss_low), .softstart_above_2v1(ss_2v1),
      .ocset_below_gnd(oc_lo), .pg_line(pg_line));
   ////////////////////////////////////////////////////////////////////////////////
   task close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         close_out();
      end
   end
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_val
   task automatic check_range(input int got, input int lo, input int hi);
      checks_done++;
      if (got < lo || got > hi) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : check_range
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic logic probe(input int sel);
      case (sel)
         0: probe = pg_oe;
         1: probe = trip;
         2: probe = dis;
         3: probe = tri_st;
         4: probe = ref_int;
         default: probe = hs_gate;
      endcase
   endfunction : probe
   task automatic wait_for(input int sel, input logic val, input int max);
      n = 0;
      while (probe(sel) !== val && n < max) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_for
   task automatic count_rise(input int sel, input int cycles);
      logic last;
      n = 0;
      last = probe(sel);
      repeat (cycles) begin
         @(posedge pclk);
         if (probe(sel) === 1'b1 && last !== 1'b1) n++;
         last = probe(sel);
      end
   endtask : count_rise
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check_val(tri_st, 1'b1);
      check_val(pg_line, 1'b0);
      apb(1'b0, buck_sup_pkg::CTRL_OFF, 32'h0);
      check_val(d, buck_sup_pkg::CTRL_RESET);
      apb(1'b0, buck_sup_pkg::DUTY_OFF, 32'h0);
      check_val(d, {16'h0000, buck_sup_pkg::DUTY_RESET});
      apb(1'b0, buck_sup_pkg::PERIOD_OFF, 32'h0);
      check_val(d, {16'h0000, buck_sup_pkg::PERIOD_RESET});
      apb(1'b1, 12'h0f0, 32'hffff_ffff);
      check_val(e, 1'b1);
      apb(1'b0, 12'h0f0, 32'h0);
      check_val({d[30:0], e}, 32'h0000_0001);
      apb(1'b1, buck_sup_pkg::PERIOD_OFF, PER);
      apb(1'b1, buck_sup_pkg::DUTY_OFF, 32'h0000_0010);
      en <= 1'b1;
      bias <= 1'b1;
      wait_for(0, 1'b0, PGD + 4000);
      check_range(n, PGD - PER, PGD + 4000);
      check_val({pg_line, ref_int, tri_st}, 3'b110);
      apb(1'b0, buck_sup_pkg::STATUS_OFF, 32'h0);
      check_val({d[10:8], d[2]}, 4'b0101);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) fb_hi <= 1'b1;
         else fb_lo <= 1'b0;
         wait_for(0, 1'b1, 20);
         check_range(n, 1, 20);
         fb_hi <= 1'b0;
         fb_lo <= 1'b1;
         wait_for(0, 1'b0, PGD + 200);
         check_range(n, PGD - PER, PGD + 2 * PER);
      end
      trk <= 1'b0;
      wait_for(4, 1'b0, 20);
      check_range(n, 1, 20);
      trk <= 1'b1;
      wait_for(4, 1'b1, 20);
      check_range(n, 1, 20);
      apb(1'b1, buck_sup_pkg::DUTY_OFF, 32'h0000_0003);
      count_rise(5, 10 * PER);
      check_range(n, 0, 0);
      apb(1'b1, buck_sup_pkg::DUTY_OFF, 32'h0000_0010);
      ss_hold <= 1'b1;
      repeat (20) @(posedge pclk);
      count_rise(5, 10 * PER);
      check_range(n, 0, 0);
      ss_hold <= 1'b0;
      count_rise(5, 2000);
      check_range(n, 1, 2000);
      oc_fault <= 1'b1;
      wait_for(1, 1'b1, 4 * PER);
      check_range(n, 1, 4 * PER);
      check_val(dis, 1'b1);
      apb(1'b0, buck_sup_pkg::STATUS_OFF, 32'h0);
      check_val(d[0], 1'b1);
      count_rise(1, 4000);
      check_range(n, 2, 4000);
      oc_fault <= 1'b0;
      repeat (4) @(posedge pclk);
      wait_for(1, 1'b0, HIC * PER + 100);
      check_range(n, 0, HIC * PER + 100);
      wait_for(2, 1'b0, 500);
      check_range(n, 0, 499);
      ot <= 1'b1;
      wait_for(2, 1'b1, 10);
      check_range(n, 1, 10);
      count_rise(5, 5 * PER);
      check_val({n[30:0], ls_gate}, 32'h0000_0000);
      ot <= 1'b0;
      wait_for(2, 1'b0, 200);
      check_range(n, 1, 200);
      oc_fault <= 1'b1;
      wait_for(1, 1'b1, 2000);
      en <= 1'b0;
      wait_for(1, 1'b0, 10);
      check_range(n, 1, 10);
      oc_fault <= 1'b0;
      en <= 1'b1;
      wait_for(3, 1'b0, 200);
      check_range(n, 1, 200);
      en <= 1'b0;
      wait_for(3, 1'b1, 10);
      check_range(n, 1, 10);
      close_out();
   end
endmodule : testbench
